// ### logic/mcm_pkg.sv
// Constants, register layout and frame layout of the management command master
// Operation
// - Write shifts the 16-bit data field out; read fills it from received bits.
// - Register index sits in bits 20:16, transceiver address in 25:21; both framed.
// - Opcode bits 27:26: 01 is write, 10 is read, others reserved.
// - Done flag in bit 28 sets when a transaction ends; resets to one.
// - With bit 29 set, an interrupt is raised at the end of each cycle.
// - Failure flag bit 30 sets when a read fails; software checks it first.
// - Bit 31 shows a host link switchover; no new commands while it is one.
// - Read frame: preamble, 01, 10, address, index, then the data line released.
// - Transceiver returns zero then data; leading bit dropped, 16 bits stored.
// - After the transfer the interrupt comes first, then the done flag.
// - Write frame: preamble, 01, 01, address, index, 10, 16 data bits, idle.
// - A whole access lasts at most 64 us from command write to done.
// - A reserved opcode causes no access on the management link.
// - Second turnaround bit not zero: abort, set failure, data 0xffff, set done.
// - On the wake-up page indices act as instructions; 0..15 remain plain registers.
// - Wake-up index 0x11 sets the space address; 0x12 moves the data.
package mcm_pkg;

    // =========================================================================
    // Register map
    localparam int          MCM_CMD_OFFSET   = 'h20;
    localparam int          MCM_DATA_LSB     = 0;
    localparam int          MCM_DATA_MSB     = 15;
    localparam int          MCM_REG_LSB      = 16;
    localparam int          MCM_REG_MSB      = 20;
    localparam int          MCM_PHY_LSB      = 21;
    localparam int          MCM_PHY_MSB      = 25;
    localparam int          MCM_OP_LSB       = 26;
    localparam int          MCM_OP_MSB       = 27;
    localparam int          MCM_READY_BIT    = 28;
    localparam int          MCM_IE_BIT       = 29;
    localparam int          MCM_ERR_BIT      = 30;
    localparam int          MCM_WAIT_BIT     = 31;
    localparam logic        MCM_READY_RST    = 1'h1;
    localparam logic [15:0] MCM_ERR_DATA     = 16'hffff;

    // =========================================================================
    // Opcodes and frame fields
    localparam logic [1:0]  MCM_OP_WRITE     = 2'h1;
    localparam logic [1:0]  MCM_OP_READ      = 2'h2;
    localparam logic [1:0]  MCM_START        = 2'h1;
    localparam logic [1:0]  MCM_TURNAROUND   = 2'h2;
    localparam logic [31:0] MCM_PREAMBLE     = 32'hffffffff;
    localparam logic [5:0]  MCM_PREAMBLE_END = 6'h20;
    localparam logic [5:0]  MCM_PHY_FIRST    = 6'h24;
    localparam logic [5:0]  MCM_RELEASE_BIT  = 6'h2e;
    localparam logic [5:0]  MCM_TA2_BIT      = 6'h2f;
    localparam logic [5:0]  MCM_DATA_FIRST   = 6'h30;
    localparam logic [5:0]  MCM_LAST_BIT     = 6'h3f;

    // =========================================================================
    // Timing
    localparam int MCM_CLK_PS       = 5000;
    localparam int MCM_MDC_HALF_NS  = 200;
    localparam int MCM_MDC_HALF_CYC = (MCM_MDC_HALF_NS * 1000 + MCM_CLK_PS - 1) / MCM_CLK_PS;
    localparam int MCM_MAX_XFER_US  = 64;
    localparam int MCM_MAX_XFER_CYC = (MCM_MAX_XFER_US * 1000000) / MCM_CLK_PS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_NOTIFY,
        ST_SETDONE
    } mcm_state_t;

endpackage : mcm_pkg

// ### logic/mcm_command_master.sv
// Register-driven management serial master with one command word register
`timescale 1ns/1ps

module mcm_command_master
    import mcm_pkg::*;
#(
    parameter int ADDR_W       = 8,
    parameter int MDC_HALF_CYC = MCM_MDC_HALF_CYC,
    parameter int MAX_XFER_CYC = MCM_MAX_XFER_CYC
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWrStb,
    input  wire logic              regRdStb,
    output logic      [31:0]       regRdData,
    // Management link
    output logic                   mdcOut,
    output logic                   mdioOut,
    output logic                   mdioOe,
    input  wire logic              mdioIn,
    // System
    input  wire logic              linkSwitching,
    output logic                   cmdIrq
);

    // =========================================================================
    // Elaboration checks
    generate
        if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
            $error("ADDR_W cannot hold the command register offset");
        end
        if (MDC_HALF_CYC < 1 || MDC_HALF_CYC > 32767) begin : g_bad_half
            $error("MDC_HALF_CYC out of range");
        end
        if (MAX_XFER_CYC < 4 * 64 * MDC_HALF_CYC || MAX_XFER_CYC > 65535) begin : g_bad_max
            $error("MAX_XFER_CYC cannot cover one frame");
        end
    endgenerate

    localparam logic [ADDR_W-1:0] CMD_ADDR = ADDR_W'(MCM_CMD_OFFSET);
    localparam logic [15:0]       HALF     = 16'(MDC_HALF_CYC);
    localparam logic [15:0]       BIT_END  = 16'(2 * MDC_HALF_CYC - 1);

    // =========================================================================
    // Input synchronisers
    logic mdioMeta_q;
    logic mdioSync_q;
    logic switchMeta_q;
    logic switchSync_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mdioMeta_q   <= 1'h1;
            mdioSync_q   <= 1'h1;
            switchMeta_q <= 1'h0;
            switchSync_q <= 1'h0;
        end else begin
            mdioMeta_q   <= mdioIn;
            mdioSync_q   <= mdioMeta_q;
            switchMeta_q <= linkSwitching;
            switchSync_q <= switchMeta_q;
        end
    end

    // =========================================================================
    // Command state
    mcm_state_t  state_q,   state_d;
    logic [15:0] data_q,    data_d;
    logic [4:0]  regIdx_q,  regIdx_d;
    logic [4:0]  phyIdx_q,  phyIdx_d;
    logic [1:0]  opcode_q,  opcode_d;
    logic        ready_q,   ready_d;
    logic        irqEn_q,   irqEn_d;
    logic        err_q,     err_d;
    logic [5:0]  bitIdx_q,  bitIdx_d;
    logic [15:0] divCnt_q,  divCnt_d;
    logic        mdc_q,     mdc_d;
    logic        out_q,     out_d;
    logic        oe_q,      oe_d;
    logic        irq_q,     irq_d;
    logic [31:0] rdData_q,  rdData_d;
    logic        cmdHit;
    logic        accept;
    logic        opValid;
    logic        isRead;
    logic [63:0] frame;
    logic [31:0] cmdWord;

    assign cmdWord = {switchSync_q, err_q, irqEn_q, ready_q,
                      opcode_q, phyIdx_q, regIdx_q, data_q};

    always_comb begin
        state_d  = state_q;
        data_d   = data_q;
        regIdx_d = regIdx_q;
        phyIdx_d = phyIdx_q;
        opcode_d = opcode_q;
        ready_d  = ready_q;
        irqEn_d  = irqEn_q;
        err_d    = err_q;
        bitIdx_d = bitIdx_q;
        divCnt_d = divCnt_q;
        irq_d    = 1'h0;
        cmdHit   = regWrStb && (regAddr == CMD_ADDR);
        // Taking commands only when idle keeps the frame fields stable mid-shift
        accept   = cmdHit && (state_q == ST_IDLE) && !switchSync_q;
        opValid  = (regWrData[MCM_OP_MSB:MCM_OP_LSB] == MCM_OP_WRITE) ||
                   (regWrData[MCM_OP_MSB:MCM_OP_LSB] == MCM_OP_READ);
        isRead   = (opcode_q == MCM_OP_READ);
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    data_d   = regWrData[MCM_DATA_MSB:MCM_DATA_LSB];
                    regIdx_d = regWrData[MCM_REG_MSB:MCM_REG_LSB];
                    phyIdx_d = regWrData[MCM_PHY_MSB:MCM_PHY_LSB];
                    opcode_d = regWrData[MCM_OP_MSB:MCM_OP_LSB];
                    irqEn_d  = regWrData[MCM_IE_BIT];
                    err_d    = regWrData[MCM_ERR_BIT];
                    // Only a cleared done flag with a valid opcode starts a frame
                    if (!regWrData[MCM_READY_BIT] && opValid) begin
                        state_d  = ST_SHIFT;
                        ready_d  = 1'h0;
                        bitIdx_d = 6'h0;
                        divCnt_d = 16'h0;
                    end else begin
                        ready_d  = 1'h1;
                    end
                end
            end
            ST_SHIFT: begin
                if (divCnt_q == BIT_END) begin
                    divCnt_d = 16'h0;
                    if (isRead && bitIdx_q == MCM_TA2_BIT && mdioSync_q) begin
                        err_d   = 1'h1;
                        data_d  = MCM_ERR_DATA;
                        state_d = ST_NOTIFY;
                    end else begin
                        if (isRead && bitIdx_q >= MCM_DATA_FIRST) begin
                            data_d = {data_q[14:0], mdioSync_q};
                        end
                        if (bitIdx_q == MCM_LAST_BIT) begin
                            state_d = ST_NOTIFY;
                        end else begin
                            bitIdx_d = bitIdx_q + 6'h1;
                        end
                    end
                end else begin
                    divCnt_d = divCnt_q + 16'h1;
                end
            end
            ST_NOTIFY: begin
                irq_d   = irqEn_q;
                state_d = ST_SETDONE;
            end
            ST_SETDONE: begin
                ready_d = 1'h1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
                ready_d = 1'h1;
            end
        endcase
        // Pins are computed from next state so they line up with bitIdx_q
        frame = {MCM_PREAMBLE, MCM_START, opcode_d, phyIdx_d, regIdx_d,
                 MCM_TURNAROUND, data_d};
        mdc_d = (state_d == ST_SHIFT) && (divCnt_d >= HALF);
        oe_d  = (state_d == ST_SHIFT) &&
                ((opcode_d == MCM_OP_WRITE) || (bitIdx_d < MCM_RELEASE_BIT));
        out_d = oe_d ? frame[MCM_LAST_BIT - bitIdx_d] : 1'h1;
        rdData_d = (regRdStb && regAddr == CMD_ADDR) ? cmdWord : 32'h0;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            data_q   <= 16'h0;
            regIdx_q <= 5'h0;
            phyIdx_q <= 5'h0;
            opcode_q <= 2'h0;
            ready_q  <= MCM_READY_RST;
            irqEn_q  <= 1'h0;
            err_q    <= 1'h0;
            bitIdx_q <= 6'h0;
            divCnt_q <= 16'h0;
            mdc_q    <= 1'h0;
            out_q    <= 1'h1;
            oe_q     <= 1'h0;
            irq_q    <= 1'h0;
            rdData_q <= 32'h0;
        end else begin
            state_q  <= state_d;
            data_q   <= data_d;
            regIdx_q <= regIdx_d;
            phyIdx_q <= phyIdx_d;
            opcode_q <= opcode_d;
            ready_q  <= ready_d;
            irqEn_q  <= irqEn_d;
            err_q    <= err_d;
            bitIdx_q <= bitIdx_d;
            divCnt_q <= divCnt_d;
            mdc_q    <= mdc_d;
            out_q    <= out_d;
            oe_q     <= oe_d;
            irq_q    <= irq_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;
    assign mdcOut    = mdc_q;
    assign mdioOut   = out_q;
    assign mdioOe    = oe_q;
    assign cmdIrq    = irq_q;

    // =========================================================================
    // Checks
    logic [15:0] busyCnt_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || ready_q) begin
            busyCnt_q <= 16'h0;
        end else begin
            busyCnt_q <= busyCnt_q + 16'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_done_after_notify;
        (state_q == ST_NOTIFY) |=> ##1 ready_q;
    endproperty
    a_done_after_notify: assert property (p_done_after_notify)
        else $error("done flag not set after transfer");

    property p_irq_before_done;
        $rose(ready_q) && irqEn_q |-> $past(cmdIrq) && !cmdIrq;
    endproperty
    a_irq_before_done: assert property (p_irq_before_done)
        else $error("interrupt did not precede done");

    property p_no_irq_disabled;
        cmdIrq |-> irqEn_q && !ready_q;
    endproperty
    a_no_irq_disabled: assert property (p_no_irq_disabled)
        else $error("interrupt raised while disabled");

    property p_reserved_no_access;
        (accept && !opValid) |=> !mdioOe [*8];
    endproperty
    a_reserved_no_access: assert property (p_reserved_no_access)
        else $error("reserved opcode drove the link");

    property p_abort_data;
        $rose(err_q) && !ready_q |-> data_q == MCM_ERR_DATA ##2 ready_q;
    endproperty
    a_abort_data: assert property (p_abort_data)
        else $error("abort did not load error data");

    property p_read_release;
        (state_q == ST_SHIFT) && isRead && (bitIdx_q >= MCM_RELEASE_BIT) |-> !mdioOe;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("data line driven during read turnaround");

    property p_preamble;
        (state_q == ST_SHIFT) && (bitIdx_q < MCM_PREAMBLE_END) |-> mdioOut && mdioOe;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("preamble bit not one");

    property p_write_data;
        (state_q == ST_SHIFT) && !isRead && (bitIdx_q >= MCM_DATA_FIRST)
            |-> mdioOut == data_q[4'(MCM_LAST_BIT - bitIdx_q)];
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("write data bit mismatch");

    property p_phy_first;
        (state_q == ST_SHIFT) && (bitIdx_q == MCM_PHY_FIRST) |-> mdioOut == phyIdx_q[4];
    endproperty
    a_phy_first: assert property (p_phy_first)
        else $error("transceiver address misplaced");

    property p_max_time;
        busyCnt_q <= 16'(MAX_XFER_CYC);
    endproperty
    a_max_time: assert property (p_max_time)
        else $error("access exceeded its time limit");

    property p_busy_ignores;
        cmdHit && !ready_q |=> $stable(phyIdx_q) && $stable(opcode_q);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores)
        else $error("command taken during transfer");

    property p_wait_blocks;
        cmdHit && switchSync_q && ready_q |=> (state_q == ST_IDLE) && !mdioOe;
    endproperty
    a_wait_blocks: assert property (p_wait_blocks)
        else $error("command taken during switchover");

    c_write_done: cover property ((state_q == ST_SETDONE) && !isRead);
    c_read_done: cover property ((state_q == ST_SETDONE) && isRead && !err_q);
    c_read_abort: cover property ($rose(err_q) && !ready_q);
    c_irq_seen: cover property (cmdIrq);

endmodule : mcm_command_master

// ### test/mcm_xcvr_model.sv
// Behavioural transceiver on the far side of the management link
`timescale 1ns/1ps

module mcm_xcvr_model (
    // Management link
    input  wire logic        mdc,
    input  wire logic        mdioLevel,
    input  wire logic        masterOe,
    output logic             xcvrOut,
    output logic             xcvrOe,
    // Scenario control
    input  wire logic [15:0] replyData,
    input  wire logic        badTurnaround,
    // What the last frame carried
    output logic [1:0]       seenOp,
    output logic [4:0]       seenPhy,
    output logic [4:0]       seenReg,
    output logic [15:0]      seenData,
    output int               frameCount
);
    int          ones;
    int          idx;
    logic [30:0] sr;

    initial begin
        {xcvrOut, xcvrOe, seenOp, seenPhy, seenReg, seenData, sr} = '0;
        {ones, idx, frameCount} = '0;
    end

    // An aborted read leaves the model mid-frame; the master taking the line back resyncs it
    always @(posedge masterOe) begin
        idx = 0;
        ones = 0;
        xcvrOe <= 1'h0;
    end

    // =========================================================================
    // Frame decode on rising management clock
    always @(posedge mdc) begin
        if (idx == 0) begin
            if (mdioLevel) begin
                ones = ones + 1;
            end else begin
                if (ones >= 32) idx = 33;
                ones = 0;
            end
        end else begin
            sr = {sr[29:0], mdioLevel};
            if (idx == 45) begin
                {seenOp, seenPhy, seenReg} = sr[11:0];
            end
            if (idx == 63) begin
                seenData = sr[15:0];
                frameCount++;
                idx = 0;
            end else begin
                idx++;
            end
        end
    end

    // =========================================================================
    // Read reply: zero turnaround bit, then data MSB first, then release
    always @(negedge mdc) begin
        if (seenOp == 2'h2 && idx >= 47) begin
            xcvrOe <= 1'h1;
            xcvrOut <= (idx == 47) ? badTurnaround : replyData[63-idx];
        end else begin
            xcvrOe <= 1'h0;
        end
    end

endmodule : mcm_xcvr_model

// ### test/mcm_command_master_tb.sv
// Self-checking testbench of the management command master
`timescale 1ns/1ps

module mcm_command_master_tb
    import mcm_pkg::*;
;
    localparam int         HALF     = 8;
    localparam logic [7:0] CMD_ADDR = 8'h20;
    localparam logic [4:0] PAGE_REG = 5'h1f;
    localparam logic [4:0] PHY      = 5'h15;

    logic        sys_clk, rst_n, regWrStb, regRdStb, linkSwitching, cmdIrq;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, got, w;
    logic        mdcOut, mdioOut, mdioOe, mdioWire, xcvrOut, xcvrOe, badTurnaround;
    logic [15:0] replyData, seenData;
    logic [1:0]  seenOp;
    logic [4:0]  seenPhy, seenReg;
    logic [1:0]  opTab [3] = '{2'h0, 2'h3, MCM_OP_WRITE};
    int          frameCount, errTotal, checksDone, cyc, irqCount, mdcEdges, f0, e0;

    // Pull-up on the data line when nobody drives it
    assign mdioWire = mdioOe ? mdioOut : (xcvrOe ? xcvrOut : 1'h1);

    mcm_command_master #(.MDC_HALF_CYC(HALF)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .mdcOut(mdcOut), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdioIn(mdioWire),
        .linkSwitching(linkSwitching), .cmdIrq(cmdIrq));

    mcm_xcvr_model u_xcvr (
        .mdc(mdcOut), .mdioLevel(mdioWire), .masterOe(mdioOe), .xcvrOut(xcvrOut),
        .xcvrOe(xcvrOe), .replyData(replyData), .badTurnaround(badTurnaround),
        .seenOp(seenOp), .seenPhy(seenPhy), .seenReg(seenReg), .seenData(seenData),
        .frameCount(frameCount));

    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cmdIrq === 1'h1) irqCount++;
    end
    always @(posedge mdcOut) mdcEdges++;

    // =========================================================================
    // Register port tasks and comparison
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'h1;
        @(posedge sys_clk);
        regWrStb <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'h1;
        @(posedge sys_clk);
        regRdStb <= 1'h0;
        #1 d = regRdData;
    endtask : rd

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] mk(input logic err, ie, rdy, input logic [1:0] op,
                                       input logic [4:0] phy, rg, input logic [15:0] dat);
        mk = {1'h0, err, ie, rdy, op, phy, rg, dat};
    endfunction : mk

    task automatic closeOut;
        $display("checks %0d errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : closeOut

    // One command from issue to done, with a refused write while busy
    task automatic xfer(input logic ie, input logic [1:0] op, input logic [4:0] rg,
                        input logic [15:0] dat, expDat, input logic expErr);
        int i0, t0, n;
        i0 = irqCount;
        f0 = frameCount;
        rd(CMD_ADDR, got);
        chk("error before command", 32'h0, {31'h0, got[30]});
        t0 = cyc;
        wr(CMD_ADDR, mk(1'h0, ie, 1'h0, op, PHY, rg, dat));
        wr(CMD_ADDR, mk(1'h0, 1'h0, 1'h0, MCM_OP_READ, ~PHY, ~rg, ~dat));
        rd(CMD_ADDR, got);
        chk("busy ready", 32'h0, {31'h0, got[28]});
        for (n = 0; n < 3000 && got[28] !== 1'h1; n++) rd(CMD_ADDR, got);
        chk("span", 32'h1, {31'h0, (cyc - t0) <= MCM_MAX_XFER_CYC});
        chk("done word", mk(expErr, ie, 1'h1, op, PHY, rg, expDat), got);
        chk("frames", f0 + (expErr ? 0 : 1), frameCount);
        chk("frame head", {op, PHY, rg}, {seenOp, seenPhy, seenReg});
        if (op == MCM_OP_WRITE) chk("written data", dat, seenData);
        chk("irq pulses", i0 + ie, irqCount);
    endtask : xfer

    // =========================================================================
    // Tests
    initial begin
        {rst_n, regWrStb, regRdStb, linkSwitching, badTurnaround} = '0;
        {regAddr, regWrData, replyData} = '0;
        {errTotal, checksDone, cyc, irqCount, mdcEdges} = '0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'h1;
        rd(CMD_ADDR, got);
        chk("reset word", 32'h1000_0000, got);
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, got);
        chk("unmapped", 32'h0, got);
        replyData <= 16'h3c5a;
        xfer(1'h1, MCM_OP_WRITE, PAGE_REG, 16'h0800, 16'h0800, 1'h0);
        xfer(1'h0, MCM_OP_WRITE, 5'h11, 16'h0123, 16'h0123, 1'h0);
        xfer(1'h1, MCM_OP_READ, 5'h12, 16'h0000, 16'h3c5a, 1'h0);
        xfer(1'h0, MCM_OP_WRITE, 5'h12, 16'hbeef, 16'hbeef, 1'h0);
        xfer(1'h0, MCM_OP_READ, 5'h0f, 16'h0000, 16'h3c5a, 1'h0);
        badTurnaround <= 1'h1;
        xfer(1'h1, MCM_OP_READ, 5'h07, 16'h1234, MCM_ERR_DATA, 1'h1);
        badTurnaround <= 1'h0;
        // Reserved codes and a command written with done set start nothing
        for (int i = 0; i < 3; i++) begin
            f0 = frameCount;
            e0 = mdcEdges;
            w = mk(1'h0, 1'h0, i == 2, opTab[i], PHY, 5'h02, 16'h5a50 + 16'(i));
            wr(CMD_ADDR, w);
            repeat (4 * HALF) @(posedge sys_clk);
            rd(CMD_ADDR, got);
            chk("refused word", w | 32'h1000_0000, got);
            chk("refused link", e0, mdcEdges);
            chk("refused frames", f0, frameCount);
        end
        w = w | 32'h1000_0000;
        linkSwitching <= 1'h1;
        repeat (3) @(posedge sys_clk);
        wr(CMD_ADDR, mk(1'h0, 1'h1, 1'h0, MCM_OP_WRITE, PHY, 5'h04, 16'h7777));
        repeat (4 * HALF) @(posedge sys_clk);
        rd(CMD_ADDR, got);
        chk("switch word", w | 32'h8000_0000, got);
        chk("switch link", e0, mdcEdges);
        linkSwitching <= 1'h0;
        repeat (3) @(posedge sys_clk);
        rd(CMD_ADDR, got);
        chk("switch over", w, got);
        closeOut;
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        errTotal++;
        closeOut;
    end

endmodule : mcm_command_master_tb
